//--- rx_split_map.svh
// offsets, field values and header lengths used by the receive header split parser
`ifndef RX_SPLIT_MAP_SVH
`define RX_SPLIT_MAP_SVH

// byte offsets from the start of the frame or of a header
`define ETH_TYPE_OFF 8'h0c
`define VLAN_INNER_OFF 8'h10
`define ETYPE_TO_IP 8'h02
`define IP_FRAG_OFF 8'h06
`define IP_PROTO_OFF 8'h09
`define IPV4_FIXED_LEN 8'h14
`define TCP_HLEN_OFF 8'h0c

// header sizes in bytes
`define VLAN_TAG_LEN 4'h4
`define SNAP_HDR_LEN 4'h8
`define ETH_HDR_LEN 8'h0e
`define IPV4_OTHER_LEN 8'h22
`define IPV4_TCP_LEN 8'h36

// fixed field values
`define VLAN_TPID 16'h8100
`define LEN_FIELD_LIMIT 16'h0600
`define SNAP_PATTERN 40'haaaa030000
`define ETHERTYPE_IPV4 16'h0800
`define IPV4_VERSION 4'h4
`define IP_PROTO_TCP 8'h06
`define NFS_PORT 16'h0801
`define FRAG_INFO_MASK 16'h3fff
`define HDR_MIN_WORDS 4'h5

// deepest byte index the parser ever reads, plus two
`define MIN_STORE_DEPTH 104

`endif

//--- rx_split_pkg.sv
// types shared by the receive header split parser
package rx_split_pkg;

   typedef enum logic [6:0] {
      ST_IDLE    = 7'b0000001,
      ST_COLLECT = 7'b0000010,
      ST_VLAN    = 7'b0000100,
      ST_SNAP    = 7'b0001000,
      ST_IP      = 7'b0010000,
      ST_TCP     = 7'b0100000,
      ST_DONE    = 7'b1000000
   } parse_state_t;

   typedef enum logic [1:0] {
      SPLIT_NONE       = 2'h0,
      SPLIT_ETH        = 2'h1,
      SPLIT_IPV4_OTHER = 2'h2,
      SPLIT_IPV4_TCP   = 2'h3
   } split_kind_t;

endpackage

//--- split_opt_len.sv
// options length of an ip or tcp header from its length nibble
`include "rx_split_map.svh"

module split_opt_len (
   // header length in 32-bit words
   input wire logic [3:0] hlen_i,
   // options length in bytes and sanity of the nibble
   output logic [5:0] opt_len_o,
   output logic ok_o
);
   logic [3:0] extra_words;

   always_comb begin
      ok_o = (hlen_i >= `HDR_MIN_WORDS);
      extra_words = ok_o ? (hlen_i - `HDR_MIN_WORDS) : 4'h0;
      // words of four bytes beyond the fixed part
      opt_len_o = {extra_words, 2'b00};
   end
endmodule

//--- hdr_byte_store.sv
// flip-flop store of the leading bytes of a frame with several read ports
module hdr_byte_store #(
   parameter int DEPTH = 128,
   parameter int NREAD = 8,
   localparam int IW = $clog2(DEPTH)
) (
   // clock
   input wire logic clk_i,
   // write port
   input wire logic wr_en_i,
   input wire logic [IW-1:0] wr_index_i,
   input wire logic [7:0] wr_data_i,
   // read ports, packed one index and one byte per port
   input wire logic [NREAD*IW-1:0] rd_index_i,
   output logic [NREAD*8-1:0] rd_data_o
);
   logic [7:0] mem [DEPTH];

   initial begin
      if (DEPTH != (1 << IW) || NREAD < 1) begin
         $error("hdr_byte_store: depth must be a power of two and ports at least one");
      end
   end

   // payload bytes only, no reset needed: stale entries are never trusted past the byte count
   always_ff @(posedge clk_i) begin
      if (wr_en_i) begin
         mem[wr_index_i] <= wr_data_i;
      end
   end

   for (genvar g = 0; g < NREAD; g++) begin : g_rd
      assign rd_data_o[g*8 +: 8] = mem[rd_index_i[g*IW +: IW]];
   end
endmodule

//--- rx_header_split_parser.sv
// receive header split parser: classifies accepted frames and gives the split position
`include "rx_split_map.svh"

module rx_header_split_parser
   import rx_split_pkg::*;
#(
   parameter int STORE_DEPTH = 128
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // receive byte stream from the filter path
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [7:0] in_data_i,
   input wire logic in_first_i,
   input wire logic in_last_i,
   input wire logic frame_accepted_i,
   // split configuration levels
   input wire logic split_enable_ethernet_only_i,
   input wire logic split_enable_ipv4_other_i,
   input wire logic split_enable_ipv4_tcp_i,
   input wire logic double_vlan_i,
   // split decision to the buffer writer
   output logic split_valid_o,
   output rx_split_pkg::split_kind_t split_kind_o,
   output logic [7:0] split_len_o
);
   import rx_split_pkg::*;

   localparam int NREAD = 8;
   localparam int IW = $clog2(STORE_DEPTH);

   initial begin
      if (STORE_DEPTH < `MIN_STORE_DEPTH || STORE_DEPTH > 256) begin
         $error("rx_header_split_parser: store depth must cover the deepest header byte and stay within 256");
      end
   end

   parse_state_t state_reg;
   parse_state_t state_next;
   logic take;
   logic [15:0] count_reg;
   logic [2:0] split_type_enable_reg;
   logic [3:0] s_reg;
   logic [3:0] d_reg;
   logic ip_ok_reg;
   logic frag_reg;
   logic proto_tcp_reg;
   logic [5:0] n_reg;
   logic tcp_ok_reg;
   logic [5:0] f_reg;
   logic split_valid_reg;
   split_kind_t split_kind_reg;
   logic [7:0] split_len_reg;

   logic [7:0] rd_at [NREAD];
   logic [7:0] rd_byte [NREAD];
   logic [NREAD*IW-1:0] rd_index_flat;
   logic [NREAD*8-1:0] rd_data_flat;
   logic [7:0] snap_base;
   logic [7:0] etype_base;
   logic [7:0] ip_base;
   logic [7:0] tcp_base;
   logic [5:0] ip_opt_len;
   logic ip_hlen_ok;
   logic [5:0] tcp_opt_len;
   logic tcp_hlen_ok;
   logic [7:0] eth_len;
   logic [7:0] other_len;
   logic [7:0] tcp_len;
   logic eth_fit;
   logic other_fit;
   logic tcp_fit;

   // a new frame waits while the previous one is still being classified
   assign in_ready_o = (state_reg == ST_IDLE) || (state_reg == ST_COLLECT);
   assign take = in_valid_i && in_ready_o;

   // header offsets grow with the optional layers found so far
   assign snap_base = `ETH_TYPE_OFF + {4'h0, s_reg};
   assign etype_base = snap_base + {4'h0, d_reg};
   assign ip_base = etype_base + `ETYPE_TO_IP;
   assign tcp_base = ip_base + `IPV4_FIXED_LEN + {2'b00, n_reg};

   // ---------------- frame byte store ----------------
   hdr_byte_store #(
      .DEPTH(STORE_DEPTH),
      .NREAD(NREAD)
   ) u_store (
      .clk_i(clk_i),
      .wr_en_i(take && (in_first_i || count_reg < 16'(STORE_DEPTH))),
      .wr_index_i(in_first_i ? IW'(0) : count_reg[IW-1:0]),
      .wr_data_i(in_data_i),
      .rd_index_i(rd_index_flat),
      .rd_data_o(rd_data_flat)
   );

   for (genvar g = 0; g < NREAD; g++) begin : g_port
      assign rd_index_flat[g*IW +: IW] = rd_at[g][IW-1:0];
      assign rd_byte[g] = rd_data_flat[g*8 +: 8];
   end

   // which bytes each stage looks at
   always_comb begin
      for (int i = 0; i < NREAD; i++) begin
         rd_at[i] = 8'h00;
      end
      unique case (state_reg)
         ST_VLAN: begin
            rd_at[0] = `ETH_TYPE_OFF;
            rd_at[1] = `ETH_TYPE_OFF + 8'h01;
            rd_at[2] = `VLAN_INNER_OFF;
            rd_at[3] = `VLAN_INNER_OFF + 8'h01;
         end
         ST_SNAP: begin
            for (int i = 0; i < 7; i++) begin
               rd_at[i] = snap_base + 8'(i);
            end
         end
         ST_IP: begin
            rd_at[0] = etype_base;
            rd_at[1] = etype_base + 8'h01;
            rd_at[2] = ip_base;
            rd_at[3] = ip_base + `IP_FRAG_OFF;
            rd_at[4] = ip_base + `IP_FRAG_OFF + 8'h01;
            rd_at[5] = ip_base + `IP_PROTO_OFF;
         end
         ST_TCP: begin
            for (int i = 0; i < 4; i++) begin
               rd_at[i] = tcp_base + 8'(i);
            end
            rd_at[4] = tcp_base + `TCP_HLEN_OFF;
         end
         ST_IDLE, ST_COLLECT, ST_DONE: begin
         end
      endcase
   end

   // ---------------- sequencing ----------------
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ST_IDLE: begin
            if (take && in_first_i) begin
               state_next = in_last_i ? (frame_accepted_i ? ST_VLAN : ST_IDLE) : ST_COLLECT;
            end
         end
         ST_COLLECT: begin
            if (take && in_last_i) begin
               // frames the filter dropped never reach the classifier
               state_next = frame_accepted_i ? ST_VLAN : ST_IDLE;
            end
         end
         ST_VLAN: state_next = ST_SNAP;
         ST_SNAP: state_next = ST_IP;
         ST_IP: state_next = ST_TCP;
         ST_TCP: state_next = ST_DONE;
         ST_DONE: state_next = ST_IDLE;
         default: state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         state_reg <= ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // byte count saturates, long frames only need to be known as long
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         count_reg <= 16'h0000;
      end else if (take && in_first_i) begin
         count_reg <= 16'h0001;
      end else if (take && count_reg != 16'hffff) begin
         count_reg <= count_reg + 16'h0001;
      end
   end

   // enables are frozen at the last byte so a mid-decision change cannot tear the result
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         split_type_enable_reg <= 3'h0;
      end else if (take && in_last_i) begin
         split_type_enable_reg <= {split_enable_ipv4_tcp_i, split_enable_ipv4_other_i,
                                   split_enable_ethernet_only_i};
      end
   end

   // ---------------- layer 2 ----------------
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         s_reg <= 4'h0;
      end else if (state_reg == ST_VLAN) begin
         if (double_vlan_i) begin
            // outer tag is taken as present and not compared, only the internal one is
            s_reg <= ({rd_byte[2], rd_byte[3]} == `VLAN_TPID) ? 4'h8 : `VLAN_TAG_LEN;
         end else if ({rd_byte[0], rd_byte[1]} == `VLAN_TPID) begin
            s_reg <= ({rd_byte[2], rd_byte[3]} == `VLAN_TPID) ? 4'h8 : `VLAN_TAG_LEN;
         end else begin
            s_reg <= 4'h0;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         d_reg <= 4'h0;
      end else if (state_reg == ST_SNAP) begin
         // the last oui byte is ignored yet still counted in the eight
         if ({rd_byte[0], rd_byte[1]} < `LEN_FIELD_LIMIT &&
             {rd_byte[2], rd_byte[3], rd_byte[4], rd_byte[5], rd_byte[6]} == `SNAP_PATTERN) begin
            d_reg <= `SNAP_HDR_LEN;
         end else begin
            d_reg <= 4'h0;
         end
      end
   end

   // ---------------- ipv4 ----------------
   split_opt_len u_ip_opt (
      .hlen_i(rd_byte[2][3:0]),
      .opt_len_o(ip_opt_len),
      .ok_o(ip_hlen_ok)
   );

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         ip_ok_reg <= 1'b0;
         frag_reg <= 1'b0;
         proto_tcp_reg <= 1'b0;
         n_reg <= 6'h00;
      end else if (state_reg == ST_IP) begin
         ip_ok_reg <= ({rd_byte[0], rd_byte[1]} == `ETHERTYPE_IPV4) &&
                      (rd_byte[2][7:4] == `IPV4_VERSION) && ip_hlen_ok;
         frag_reg <= (({rd_byte[3], rd_byte[4]} & `FRAG_INFO_MASK) != 16'h0000);
         proto_tcp_reg <= (rd_byte[5] == `IP_PROTO_TCP);
         n_reg <= ip_opt_len;
      end
   end

   // ---------------- tcp ----------------
   split_opt_len u_tcp_opt (
      .hlen_i(rd_byte[4][7:4]),
      .opt_len_o(tcp_opt_len),
      .ok_o(tcp_hlen_ok)
   );

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         tcp_ok_reg <= 1'b0;
         f_reg <= 6'h00;
      end else if (state_reg == ST_TCP) begin
         tcp_ok_reg <= ({rd_byte[0], rd_byte[1]} != `NFS_PORT) &&
                       ({rd_byte[2], rd_byte[3]} != `NFS_PORT) && tcp_hlen_ok;
         f_reg <= tcp_opt_len;
      end
   end

   // ---------------- decision ----------------
   // every byte up to the split point counts, ignored fields included
   assign eth_len = `ETH_HDR_LEN + {4'h0, s_reg} + {4'h0, d_reg};
   assign other_len = `IPV4_OTHER_LEN + {4'h0, s_reg} + {4'h0, d_reg} + {2'b00, n_reg};
   assign tcp_len = `IPV4_TCP_LEN + {4'h0, s_reg} + {4'h0, d_reg} + {2'b00, n_reg} +
                    {2'b00, f_reg};

   // a split beyond the frame's end would cut nothing real
   assign eth_fit = count_reg >= {8'h00, eth_len};
   assign other_fit = count_reg >= {8'h00, other_len};
   assign tcp_fit = count_reg >= {8'h00, tcp_len};

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         split_kind_reg <= SPLIT_NONE;
         split_len_reg <= 8'h00;
      end else if (state_reg == ST_DONE) begin
         if (split_type_enable_reg[2] && ip_ok_reg && !frag_reg && proto_tcp_reg &&
             tcp_ok_reg && tcp_fit) begin
            split_kind_reg <= SPLIT_IPV4_TCP;
            split_len_reg <= tcp_len;
         end else if (split_type_enable_reg[1] && ip_ok_reg && frag_reg && other_fit) begin
            // fragments never take the tcp split, so protocol plays no part here
            split_kind_reg <= SPLIT_IPV4_OTHER;
            split_len_reg <= other_len;
         end else if (split_type_enable_reg[0] && eth_fit) begin
            split_kind_reg <= SPLIT_ETH;
            split_len_reg <= eth_len;
         end else begin
            split_kind_reg <= SPLIT_NONE;
            split_len_reg <= 8'h00;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         split_valid_reg <= 1'b0;
      end else begin
         split_valid_reg <= (state_reg == ST_DONE);
      end
   end

   assign split_valid_o = split_valid_reg;
   assign split_kind_o = split_kind_reg;
   assign split_len_o = split_len_reg;
endmodule

//--- rx_header_split_parser_sva.sv
// port assertions for the receive header split parser
module rx_header_split_parser_sva
   import rx_split_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // byte stream
   input wire logic in_valid_i,
   input wire logic in_ready_o,
   input wire logic in_last_i,
   input wire logic frame_accepted_i,
   // enables
   input wire logic split_enable_ethernet_only_i,
   input wire logic split_enable_ipv4_other_i,
   input wire logic split_enable_ipv4_tcp_i,
   // decision
   input wire logic split_valid_o,
   input wire rx_split_pkg::split_kind_t split_kind_o,
   input wire logic [7:0] split_len_o
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   logic take_last;
   assign take_last = in_valid_i && in_ready_o && in_last_i && frame_accepted_i;
   sequence s_take_last;
      take_last;
   endsequence
   // five dead cycles while the stored header is walked
   sequence s_hold_off;
      !in_ready_o [*5] ##1 in_ready_o;
   endsequence
   a_decision_latency: assert property (s_take_last |-> ##6 split_valid_o)
      else $error("no decision six cycles after accepted last byte");
   a_decision_cause: assert property (split_valid_o |-> $past(take_last, 6))
      else $error("decision without accepted frame");
   a_ready_holdoff: assert property (s_take_last |=> s_hold_off)
      else $error("ready not held off for five cycles");
   a_pulse_single: assert property (split_valid_o |=> !split_valid_o)
      else $error("decision pulse longer than one cycle");
   a_result_hold: assert property (!split_valid_o |-> $stable(split_kind_o) && $stable(split_len_o))
      else $error("kind or length moved between decisions");
   a_none_len_zero: assert property (split_valid_o && split_kind_o == SPLIT_NONE |-> split_len_o == 8'h00)
      else $error("unsplit frame with nonzero length");
   a_eth_len_set: assert property (split_valid_o && split_kind_o == SPLIT_ETH
      |-> split_len_o inside {8'h0e, 8'h12, 8'h16, 8'h1a, 8'h1e})
      else $error("ethernet split length off");
   a_other_len_form: assert property (split_valid_o && split_kind_o == SPLIT_IPV4_OTHER
      |-> split_len_o >= 8'h22 && split_len_o[1:0] == 2'h2)
      else $error("ipv4 other length off");
   a_tcp_len_form: assert property (split_valid_o && split_kind_o == SPLIT_IPV4_TCP
      |-> split_len_o >= 8'h36 && split_len_o[1:0] == 2'h2)
      else $error("tcp length off");
   a_tcp_enable_gate: assert property (split_valid_o && split_kind_o == SPLIT_IPV4_TCP
      |-> $past(split_enable_ipv4_tcp_i, 6))
      else $error("tcp split while disabled");
   a_other_enable_gate: assert property (split_valid_o && split_kind_o == SPLIT_IPV4_OTHER
      |-> $past(split_enable_ipv4_other_i, 6))
      else $error("ipv4 other split while disabled");
   a_eth_enable_gate: assert property (split_valid_o && split_kind_o == SPLIT_ETH
      |-> $past(split_enable_ethernet_only_i, 6))
      else $error("ethernet split while disabled");
endmodule

bind rx_header_split_parser rx_header_split_parser_sva u_rx_header_split_parser_sva (.clk_i(clk_i),
   .reset_n_i(reset_n_i), .in_valid_i(in_valid_i), .in_ready_o(in_ready_o), .in_last_i(in_last_i),
   .frame_accepted_i(frame_accepted_i), .split_enable_ethernet_only_i(split_enable_ethernet_only_i),
   .split_enable_ipv4_other_i(split_enable_ipv4_other_i), .split_enable_ipv4_tcp_i(split_enable_ipv4_tcp_i),
   .split_valid_o(split_valid_o), .split_kind_o(split_kind_o), .split_len_o(split_len_o));

//--- rx_frame_source.sv
// behavioural receive filter path that streams one stored frame per go request
module rx_frame_source (
   // clock
   input wire logic clk_i,
   // frame request
   input wire logic go_i,
   input wire logic slow_i,
   input wire logic [7:0] len_i,
   input wire logic [7:0] mem_i [128],
   // byte stream
   input wire logic ready_i,
   output logic valid_o,
   output logic [7:0] data_o,
   output logic first_o,
   output logic last_o,
   output logic busy_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // ready is looked at on the falling edge so the rising edge race never decides a take
   initial begin
      valid_o = 1'b0;
      data_o = 8'h00;
      first_o = 1'b0;
      last_o = 1'b0;
      busy_o = 1'b0;
      forever begin
         do @(negedge clk_i); while (go_i !== 1'b1);
         @(posedge clk_i);
         for (int i = 0; i < len_i; i++) begin
            #1 busy_o = 1'b1;
            if (slow_i && i[0]) begin
               valid_o = 1'b0;
               data_o = ~data_o;
               @(posedge clk_i);
               #1;
            end
            valid_o = 1'b1;
            data_o = mem_i[i];
            first_o = (i == 0);
            last_o = (i == len_i - 1);
            do @(negedge clk_i); while (ready_i !== 1'b1);
            @(posedge clk_i);
         end
         // released data shows the inverse so a stale byte is never read as valid
         #1 valid_o = 1'b0;
         data_o = ~data_o;
         first_o = 1'b0;
         last_o = 1'b0;
         busy_o = 1'b0;
      end
   end
endmodule

//--- rx_header_split_parser_test.sv
// self-checking bench for the receive header split parser
module rx_header_split_parser_test;
   timeunit 1ns;
   timeprecision 100ps;
   import rx_split_pkg::*;
   logic clk_i;
   logic reset_n_i;
   logic in_valid, in_ready, in_first, in_last, busy, split_valid;
   logic acc, go, slow, dv;
   logic [7:0] in_data, split_len;
   logic [7:0] n;
   logic [2:0] en;
   split_kind_t split_kind;
   logic [7:0] fr [128];
   int miscompares = 0;
   int tests_run = 0;
   always #5 clk_i = ~clk_i;
   rx_header_split_parser u_rx_header_split_parser (.clk_i(clk_i), .reset_n_i(reset_n_i), .in_valid_i(in_valid),
      .in_ready_o(in_ready), .in_data_i(in_data), .in_first_i(in_first), .in_last_i(in_last),
      .frame_accepted_i(acc), .split_enable_ethernet_only_i(en[0]), .split_enable_ipv4_other_i(en[1]),
      .split_enable_ipv4_tcp_i(en[2]), .double_vlan_i(dv), .split_valid_o(split_valid),
      .split_kind_o(split_kind), .split_len_o(split_len));
   rx_frame_source u_rx_frame_source (.clk_i(clk_i), .go_i(go), .slow_i(slow), .len_i(n), .mem_i(fr),
      .ready_i(in_ready), .valid_o(in_valid), .data_o(in_data), .first_o(in_first), .last_o(in_last),
      .busy_o(busy));
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic report_and_stop();
      if (miscompares == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // filler never forms a tag, length or port value by accident
   task automatic build(input int nv = 0, input bit snap = 0, input logic [15:0] et = 16'h0800,
      input logic [7:0] vi = 8'h45, input logic [15:0] fg = 16'h0000, input logic [7:0] pr = 8'h06,
      input logic [15:0] sp = 16'h1234, input logic [15:0] dp = 16'h0050, input logic [3:0] tl = 4'h5);
      int p;
      int q;
      for (int i = 0; i < 128; i++) fr[i] = 8'(i) ^ 8'h5a;
      p = 12;
      repeat (nv) begin
         {fr[p], fr[p+1]} = 16'h8100;
         p += 4;
      end
      if (snap) begin
         {fr[p], fr[p+1], fr[p+2], fr[p+3], fr[p+4], fr[p+5], fr[p+6]} = 56'h0040aaaa030000;
         p += 8;
      end
      {fr[p], fr[p+1]} = et;
      fr[p+2] = vi;
      {fr[p+8], fr[p+9]} = fg;
      fr[p+11] = pr;
      q = p + 2 + 4 * vi[3:0];
      {fr[q], fr[q+1], fr[q+2], fr[q+3]} = {sp, dp};
      fr[q+12] = {tl, 4'h0};
   endtask
   task automatic send(input logic a, input logic [2:0] e, input logic [1:0] ek, input logic [7:0] el);
      int w;
      logic hit;
      logic [1:0] k;
      logic [7:0] l;
      acc = a;
      en = e;
      go = 1'b1;
      @(posedge clk_i);
      #1 go = 1'b0;
      w = 0;
      do begin
         @(posedge clk_i);
         w++;
      end while (busy === 1'b1 && w < 400);
      hit = 1'b0;
      repeat (12) begin
         @(posedge clk_i);
         #1;
         if (split_valid === 1'b1) begin
            hit = 1'b1;
            k = split_kind;
            l = split_len;
         end
      end
      check("frame_done", 16'(w == 400), 16'h0000);
      check("split_valid", 16'(hit), 16'(a));
      if (a) begin
         check("split_kind", 16'(k), 16'(ek));
         check("split_len", 16'(l), 16'(el));
      end
   endtask
   task automatic t_eth_only();
      build(.nv(1));
      send(1, 3'b001, SPLIT_ETH, 8'd14 + 8'd4);
   endtask
   task automatic t_tcp_full();
      slow = 1'b1;
      build(.nv(2), .snap(1), .vi(8'h46), .tl(4'h7));
      send(1, 3'b111, SPLIT_IPV4_TCP, 8'd54 + 8'd8 + 8'd8 + 8'd4 + 8'd8);
      slow = 1'b0;
   endtask
   task automatic t_nfs();
      build(.sp(16'h0801));
      send(1, 3'b101, SPLIT_ETH, 8'd14);
      build(.dp(16'h0801));
      send(1, 3'b100, SPLIT_NONE, 8'd0);
   endtask
   task automatic t_frag();
      build(.vi(8'h47), .fg(16'h2000));
      send(1, 3'b010, SPLIT_IPV4_OTHER, 8'd34 + 8'd8);
      build(.nv(1), .fg(16'h0005), .pr(8'h11));
      send(1, 3'b110, SPLIT_IPV4_OTHER, 8'd34 + 8'd4);
   endtask
   task automatic t_unfrag();
      build(.pr(8'h11));
      send(1, 3'b010, SPLIT_NONE, 8'd0);
      build(.fg(16'h4000));
      send(1, 3'b011, SPLIT_ETH, 8'd14);
   endtask
   task automatic t_compare();
      build(.et(16'h0801));
      send(1, 3'b111, SPLIT_ETH, 8'd14);
      build(.vi(8'h55));
      send(1, 3'b111, SPLIT_ETH, 8'd14);
      build(.snap(1));
      fr[16] = 8'h02;
      send(1, 3'b111, SPLIT_ETH, 8'd14);
   endtask
   task automatic t_edge();
      build();
      n = 8'd54;
      send(1, 3'b101, SPLIT_IPV4_TCP, 8'd54);
      n = 8'd53;
      send(1, 3'b101, SPLIT_ETH, 8'd14);
      n = 8'd100;
   endtask
   task automatic t_reject();
      build();
      send(0, 3'b111, SPLIT_NONE, 8'd0);
      send(0, 3'b111, SPLIT_NONE, 8'd0);
   endtask
   task automatic t_dvlan();
      build(.nv(2));
      {fr[12], fr[13]} = 16'h88a8;
      dv = 1'b1;
      send(1, 3'b001, SPLIT_ETH, 8'd22);
      dv = 1'b0;
      send(1, 3'b001, SPLIT_ETH, 8'd14);
   endtask
   initial begin
      #100000;
      miscompares++;
      report_and_stop();
   end
   initial begin
      clk_i = 1'b0;
      reset_n_i = 1'b0;
      acc = 1'b0;
      go = 1'b0;
      slow = 1'b0;
      dv = 1'b0;
      n = 8'd100;
      en = 3'h0;
      repeat (5) @(posedge clk_i);
      #1 reset_n_i = 1'b1;
      @(posedge clk_i);
      #1;
      t_eth_only();
      t_tcp_full();
      t_nfs();
      t_frag();
      t_unfrag();
      t_compare();
      t_edge();
      t_reject();
      t_dvlan();
      report_and_stop();
   end
endmodule
